// *** src/dti_i2c_slave.sv ***
`timescale 1ns/1ps
module dti_i2c_slave import dti_pkg::*; #(
	// Arbitrary value, not a real identifier
	parameter logic [3:0] DEV_TYPE_ID = 4'h5,
	parameter int FIFO_DEPTH = DTI_FIFO_DEPTH
) (
	// Clocks and reset
	input wire logic clk,
	input wire logic rst_b,
	input wire logic rf_clk,
	// Serial bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// RF core status, rf_clk domain
	input wire logic rf_write_busy,
	input wire logic rf_cmd_busy,
	// Configuration and supply pins
	input wire logic rf_command_progress_mode,
	input wire logic supply_ok,
	// RF activity pin
	output logic rf_activity_out,
	output logic rf_activity_oe,
	// Power state
	output logic standby
);

	localparam int WR_W = $bits(dti_wr_type);

	// ----------------------------------------------------------------
	// RF core status capture in its own domain
	// ----------------------------------------------------------------
	logic [1:0] rf_q, rf_d;

	always_comb
	begin
		rf_d = {rf_cmd_busy, rf_write_busy};
	end

	always_ff @(posedge rf_clk or negedge rst_b)
	begin
		if (!rst_b)
			rf_q <= DTI_RF_RST;
		else
			rf_q <= rf_d;
	end

	// ----------------------------------------------------------------
	// Pin and status synchronisers, bus edge detect
	// ----------------------------------------------------------------
	logic [2:0] scl_s_q, scl_s_d, sda_s_q, sda_s_d;
	logic [DTI_SYNC_W-1:0] sy1_q, sy1_d, sy2_q, sy2_d;
	logic scl_rise, scl_fall, bus_start, bus_stop, sda_s;
	logic wr_busy_s, cmd_busy_s, mode_s, supply_s;

	always_comb
	begin
		scl_s_d = {scl_s_q[1:0], scl_in};
		sda_s_d = {sda_s_q[1:0], sda_in};
		sda_s = sda_s_q[1];
		scl_rise = scl_s_q[1] && !scl_s_q[2];
		scl_fall = !scl_s_q[1] && scl_s_q[2];
		bus_start = scl_s_q[1] && scl_s_q[2] &&
			sda_s_q[2] && !sda_s_q[1];
		bus_stop = scl_s_q[1] && scl_s_q[2] &&
			!sda_s_q[2] && sda_s_q[1];
		sy1_d = {supply_ok, rf_command_progress_mode, rf_q};
		sy2_d = sy1_q;
		wr_busy_s = sy2_q[0];
		cmd_busy_s = sy2_q[1];
		mode_s = sy2_q[2];
		supply_s = sy2_q[3];
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			scl_s_q <= DTI_PIN_SYNC_RST;
			sda_s_q <= DTI_PIN_SYNC_RST;
			sy1_q <= DTI_SYNC_RST;
			sy2_q <= DTI_SYNC_RST;
		end
		else
		begin
			scl_s_q <= scl_s_d;
			sda_s_q <= sda_s_d;
			sy1_q <= sy1_d;
			sy2_q <= sy2_d;
		end
	end

	// ----------------------------------------------------------------
	// Write buffer and memory
	// ----------------------------------------------------------------
	logic [7:0] mem_q [DTI_MEM_DEPTH];
	dti_wr_type wr_in, wr_out;
	logic wr_push, wr_ready, wr_pend, wr_pop;
	logic [WR_W-1:0] wr_out_bits;
	logic [7:0] mem_rd;

	dti_fifo #(
		.WIDTH(WR_W),
		.DEPTH(FIFO_DEPTH)
	) u_wr_fifo (
		.clk(clk),
		.rst_b(rst_b),
		.in_valid(wr_push),
		.in_ready(wr_ready),
		.in_data(wr_in),
		.out_valid(wr_pend),
		.out_ready(wr_pop),
		.out_data(wr_out_bits)
	);

	always_comb
	begin
		wr_out = dti_wr_type'(wr_out_bits);
		// RF write cycles own the array; bus writes wait
		wr_pop = !wr_busy_s;
		mem_rd = mem_q[wr_in.addr];
	end

	always_ff @(posedge clk)
	begin
		if (wr_pend && wr_pop)
			mem_q[wr_out.addr] <= wr_out.data;
	end

	// ----------------------------------------------------------------
	// Serial protocol engine
	// ----------------------------------------------------------------
	dti_state_type state_q, state_d;
	dti_kind_type kind_q, kind_d;
	logic [3:0] cnt_q, cnt_d;
	logic [7:0] shift_q, shift_d;
	logic [DTI_ADDR_W-1:0] addr_q, addr_d;
	logic rw_q, rw_d, mack_q, mack_d, oe_q, oe_d;
	logic load_tx;

	always_comb
	begin
		state_d = state_q;
		kind_d = kind_q;
		cnt_d = cnt_q;
		shift_d = shift_q;
		addr_d = addr_q;
		rw_d = rw_q;
		mack_d = mack_q;
		oe_d = oe_q;
		wr_push = 1'b0;
		load_tx = 1'b0;
		wr_in.addr = addr_q;
		wr_in.data = shift_q;
		case (state_q)
			DTI_ST_IDLE:
			begin
				oe_d = 1'b0;
			end
			DTI_ST_RX:
			begin
				if (scl_rise && cnt_q != DTI_BYTE_BITS)
				begin
					shift_d = {shift_q[6:0], sda_s};
					cnt_d = cnt_q + 4'h1;
				end
				else if (scl_fall && cnt_q == DTI_BYTE_BITS)
				begin
					cnt_d = DTI_CNT_RST;
					state_d = DTI_ST_ACK;
					oe_d = 1'b1;
					case (kind_q)
						DTI_K_DEV:
						begin
							// Area bit b3 is accepted for either area
							if (shift_q[7:4] == DEV_TYPE_ID &&
								shift_q[2:1] == DTI_FIXED_BITS)
							begin
								rw_d = shift_q[0];
								kind_d = DTI_K_AHI;
							end
							else
							begin
								state_d = DTI_ST_IDLE;
								oe_d = 1'b0;
							end
						end
						DTI_K_AHI:
						begin
							addr_d = {shift_q[0], addr_q[7:0]};
							kind_d = DTI_K_ALO;
						end
						DTI_K_ALO:
						begin
							addr_d = {addr_q[8], shift_q};
							kind_d = DTI_K_DATA;
						end
						DTI_K_DATA:
						begin
							if (wr_ready)
							begin
								wr_push = 1'b1;
								addr_d = addr_q + 9'h001;
							end
							else
								oe_d = 1'b0;
						end
						default:
						begin
							state_d = DTI_ST_IDLE;
							oe_d = 1'b0;
						end
					endcase
				end
			end
			DTI_ST_ACK:
			begin
				if (scl_fall)
				begin
					oe_d = 1'b0;
					if (rw_q)
						load_tx = 1'b1;
					else
						state_d = DTI_ST_RX;
				end
			end
			DTI_ST_TX:
			begin
				if (scl_fall)
				begin
					if (cnt_q == DTI_LAST_TX_BIT)
					begin
						state_d = DTI_ST_MACK;
						oe_d = 1'b0;
					end
					else
					begin
						cnt_d = cnt_q + 4'h1;
						shift_d = {shift_q[6:0], 1'b0};
						oe_d = !shift_q[6];
					end
				end
			end
			DTI_ST_MACK:
			begin
				if (scl_rise)
					mack_d = !sda_s;
				if (scl_fall)
				begin
					if (mack_q)
						load_tx = 1'b1;
					else
						state_d = DTI_ST_IDLE;
				end
			end
			default:
			begin
				state_d = DTI_ST_IDLE;
				oe_d = 1'b0;
			end
		endcase
		if (load_tx)
		begin
			// Bytes still queued for the array are not seen here
			shift_d = mem_rd;
			addr_d = addr_q + 9'h001;
			oe_d = !mem_rd[7];
			cnt_d = DTI_CNT_RST;
			state_d = DTI_ST_TX;
		end
		if (bus_stop)
		begin
			state_d = DTI_ST_IDLE;
			oe_d = 1'b0;
		end
		if (bus_start)
		begin
			state_d = DTI_ST_RX;
			kind_d = DTI_K_DEV;
			cnt_d = DTI_CNT_RST;
			oe_d = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_q <= DTI_ST_IDLE;
			kind_q <= DTI_K_DEV;
			cnt_q <= DTI_CNT_RST;
			shift_q <= DTI_SHIFT_RST;
			addr_q <= DTI_ADDR_RST;
			rw_q <= 1'b0;
			mack_q <= 1'b0;
			oe_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			kind_q <= kind_d;
			cnt_q <= cnt_d;
			shift_q <= shift_d;
			addr_q <= addr_d;
			rw_q <= rw_d;
			mack_q <= mack_d;
			oe_q <= oe_d;
		end
	end

	// ----------------------------------------------------------------
	// Output flops
	// ----------------------------------------------------------------
	logic act_oe_q, act_oe_d, stby_q, stby_d, zero_q;

	always_comb
	begin
		act_oe_d = supply_s &&
			(mode_s ? cmd_busy_s
				: wr_busy_s);
		stby_d = (state_q == DTI_ST_IDLE) && !wr_pend;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			act_oe_q <= 1'b0;
			stby_q <= 1'b1;
			zero_q <= 1'b0;
		end
		else
		begin
			act_oe_q <= act_oe_d;
			stby_q <= stby_d;
			zero_q <= 1'b0;
		end
	end

	assign sda_out = zero_q;
	assign sda_oe = oe_q;
	assign rf_activity_out = zero_q;
	assign rf_activity_oe = act_oe_q;
	assign standby = stby_q;

endmodule : dti_i2c_slave

// *** src/dti_pkg.sv ***
package dti_pkg;

	// ----------------------------------------------------------------
	// Memory view and byte framing
	// ----------------------------------------------------------------
	localparam int DTI_MEM_DEPTH = 512;
	localparam int DTI_ADDR_W = 9;
	localparam int DTI_FIFO_DEPTH = 8;
	localparam logic [3:0] DTI_BYTE_BITS = 4'h8;
	localparam logic [3:0] DTI_LAST_TX_BIT = 4'h7;
	localparam logic [1:0] DTI_FIXED_BITS = 2'h3;
	localparam int DTI_SYNC_W = 4;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [DTI_ADDR_W-1:0] DTI_ADDR_RST = 9'h000;
	localparam logic [7:0] DTI_SHIFT_RST = 8'h00;
	localparam logic [3:0] DTI_CNT_RST = 4'h0;
	localparam logic [2:0] DTI_PIN_SYNC_RST = 3'h7;
	localparam logic [1:0] DTI_RF_RST = 2'h0;
	localparam logic [DTI_SYNC_W-1:0] DTI_SYNC_RST = 4'h0;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		DTI_ST_IDLE,
		DTI_ST_RX,
		DTI_ST_ACK,
		DTI_ST_TX,
		DTI_ST_MACK
	} dti_state_type;

	typedef enum logic [1:0] {
		DTI_K_DEV,
		DTI_K_AHI,
		DTI_K_ALO,
		DTI_K_DATA
	} dti_kind_type;

	typedef struct packed {
		logic [DTI_ADDR_W-1:0] addr;
		logic [7:0] data;
	} dti_wr_type;

endpackage : dti_pkg

// *** src/dti_fifo.sv ***
`timescale 1ns/1ps
module dti_fifo import dti_pkg::*; #(
	parameter int WIDTH = 17,
	parameter int DEPTH = DTI_FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [PW:0] cnt_q, cnt_d;
	logic push, pop;

	// ----------------------------------------------------------------
	// Pointers and fill level
	// ----------------------------------------------------------------
	always_comb
	begin
		in_ready = (cnt_q != (PW+1)'(DEPTH));
		out_valid = (cnt_q != '0);
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		out_data = mem_q[rp_q];
		wp_d = push ? PW'((wp_q + 1'b1) % DEPTH) : wp_q;
		rp_d = pop ? PW'((rp_q + 1'b1) % DEPTH) : rp_q;
		cnt_d = cnt_q;
		if (push && !pop)
			cnt_d = cnt_q + 1'b1;
		else if (pop && !push)
			cnt_d = cnt_q - 1'b1;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			wp_q <= wp_d;
			rp_q <= rp_d;
			cnt_q <= cnt_d;
		end
	end

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (push)
			mem_q[wp_q] <= in_data;
	end

endmodule : dti_fifo

// *** verif/dti_mst_model.sv ***
`timescale 1ns/1ps
module dti_mst_model (
	// Clock
	input wire logic clk,
	// Bus pins
	output logic scl,
	output logic sda_pull,
	input wire logic sda
);
	initial
	begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	task automatic hp;
		repeat (6) @(posedge clk);
		#1;
	endtask : hp
	task automatic start;
		hp;
		sda_pull = 1'b0;
		hp;
		scl = 1'b1;
		hp;
		sda_pull = 1'b1;
		hp;
		scl = 1'b0;
	endtask : start
	task automatic stop;
		hp;
		sda_pull = 1'b1;
		hp;
		scl = 1'b1;
		hp;
		sda_pull = 1'b0;
		hp;
	endtask : stop
	task automatic bt(input logic v, output logic s);
		hp;
		sda_pull = !v;
		hp;
		scl = 1'b1;
		hp;
		s = sda;
		scl = 1'b0;
	endtask : bt
	task automatic wr(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bt(b[i], s);
		bt(1'b1, s);
		ack = !s;
	endtask : wr
	task automatic rd(input logic nack, output logic [7:0] d);
		logic s;
		for (int i = 0; i < 8; i++)
		begin
			bt(1'b1, s);
			d = {d[6:0], s};
		end
		bt(nack, s);
	endtask : rd
endmodule : dti_mst_model

// *** verif/dti_i2c_slave_chk.sv ***
`timescale 1ns/1ps
module dti_i2c_slave_chk (
	// Clocks and reset
	input wire logic clk,
	input wire logic rst_b,
	input wire logic rf_clk,
	// Bus and status
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic rf_write_busy,
	input wire logic rf_cmd_busy,
	input wire logic rf_command_progress_mode,
	input wire logic supply_ok,
	input wire logic rf_activity_out,
	input wire logic rf_activity_oe,
	input wire logic standby
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	chk_sda_low: assert property (sda_out == 1'b0)
		else $error("data pin driven high");
	chk_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("data drive changed with clock high");
	chk_busy_active: assert property (sda_oe |-> !standby)
		else $error("standby while driving");
	chk_stop_idle: assert property (
		scl_in && $rose(sda_in) && !rf_write_busy |-> ##[1:30] standby)
		else $error("no standby after stop");
	chk_act_supply: assert property (
		!supply_ok [*6] |-> !rf_activity_oe)
		else $error("activity without supply");
	chk_act_quiet: assert property (
		(supply_ok && !rf_write_busy && !rf_cmd_busy) [*8]
		|-> !rf_activity_oe)
		else $error("activity while idle");
	chk_act_write: assert property (
		(supply_ok && !rf_command_progress_mode && rf_write_busy) [*8]
		|-> rf_activity_oe)
		else $error("write activity missing");
	chk_act_cmd: assert property (
		(supply_ok && rf_command_progress_mode && rf_cmd_busy) [*8]
		|-> rf_activity_oe)
		else $error("command activity missing");
	chk_act_low: assert property (rf_activity_out == 1'b0)
		else $error("activity pin driven high");
	cover property ($rose(sda_oe));
	cover property ($rose(rf_activity_oe));
	cover property ($fell(standby));
endmodule : dti_i2c_slave_chk
bind dti_i2c_slave dti_i2c_slave_chk i_chk (.clk(clk), .rst_b(rst_b),
	.rf_clk(rf_clk), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
	.sda_oe(sda_oe), .rf_write_busy(rf_write_busy),
	.rf_cmd_busy(rf_cmd_busy),
	.rf_command_progress_mode(rf_command_progress_mode),
	.supply_ok(supply_ok), .rf_activity_out(rf_activity_out),
	.rf_activity_oe(rf_activity_oe), .standby(standby));

// *** verif/test_dti_i2c_slave.sv ***
`timescale 1ns/1ps
module test_dti_i2c_slave;
	// Arbitrary identifier value
	localparam logic [3:0] ID = 4'h9;
	logic clk = 1'b0;
	logic rf_clk = 1'b0;
	logic rst_b = 1'b0;
	logic rf_write_busy = 1'b0, rf_cmd_busy = 1'b0;
	logic mode = 1'b0, supply_ok = 1'b1;
	logic scl, m_pull, sda, sda_out, sda_oe, act_out, act_oe, standby, a;
	logic [7:0] d;
	int error_cnt = 0, checks = 0, cyc = 0;
	// Pull-up on the data wire
	assign sda = (sda_oe ? sda_out : 1'b1) & !m_pull;
	always #50 clk = ~clk;
	initial
	begin
		#7;
		forever #24 rf_clk = ~rf_clk;
	end
	dti_i2c_slave #(.DEV_TYPE_ID(ID)) i_dut (.clk(clk), .rst_b(rst_b),
		.rf_clk(rf_clk), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe(sda_oe), .rf_write_busy(rf_write_busy),
		.rf_cmd_busy(rf_cmd_busy), .rf_command_progress_mode(mode),
		.supply_ok(supply_ok), .rf_activity_out(act_out),
		.rf_activity_oe(act_oe), .standby(standby));
	dti_mst_model i_mst (.clk(clk), .scl(scl), .sda_pull(m_pull), .sda(sda));
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic complete_run;
		$display("Errors %0d, checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			error_cnt++;
			complete_run;
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic cy(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cy
	function automatic logic [7:0] sel(input logic b3, input logic rw);
		return {ID, b3, 2'h3, rw};
	endfunction : sel
	task automatic w(input logic [7:0] b, input logic e);
		i_mst.wr(b, a);
		chk({7'h00, a}, {7'h00, e});
	endtask : w
	task automatic r(input logic nack, input logic [7:0] e);
		i_mst.rd(nack, d);
		chk(d, e);
	endtask : r
	task automatic setad(input logic b3, input logic [8:0] ad);
		i_mst.start;
		w(sel(b3, 1'b0), 1'b1);
		w({7'h00, ad[8]}, 1'b1);
		w(ad[7:0], 1'b1);
	endtask : setad
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_rf;
		for (int k = 0; k < 16; k++)
		begin
			@(posedge rf_clk);
			#1;
			{rf_write_busy, rf_cmd_busy} = k[1:0];
			cy(1);
			{supply_ok, mode} = k[3:2];
			cy(10);
			chk({7'h00, act_oe}, {7'h00, supply_ok &
				(mode ? rf_cmd_busy : rf_write_busy)});
			chk({7'h00, act_out}, 8'h00);
		end
		@(posedge rf_clk);
		#1;
		{rf_write_busy, rf_cmd_busy} = 2'h0;
		cy(1);
		mode = 1'b0;
	endtask : t_rf
	task automatic t_bad;
		for (int k = 0; k < 2; k++)
		begin
			i_mst.start;
			w(k ? {ID, 4'h2} : {~ID, 4'h6}, 1'b0);
			w(8'h55, 1'b0);
			chk({7'h00, sda_out}, 8'h00);
			i_mst.stop;
		end
	endtask : t_bad
	task automatic t_wr;
		setad(1'b0, 9'h1ff);
		w(8'ha5, 1'b1);
		w(8'h3c, 1'b1);
		i_mst.stop;
		cy(30);
		chk({7'h00, standby}, 8'h01);
		setad(1'b1, 9'h1ff);
		i_mst.start;
		w(sel(1'b0, 1'b1), 1'b1);
		r(1'b0, 8'ha5);
		r(1'b1, 8'h3c);
		i_mst.stop;
	endtask : t_wr
	task automatic t_full;
		@(posedge rf_clk);
		#1;
		rf_write_busy = 1'b1;
		setad(1'b0, 9'h010);
		for (int k = 0; k < 9; k++) w(k[7:0], k < 8);
		i_mst.stop;
		cy(30);
		chk({7'h00, standby}, 8'h00);
		chk({7'h00, act_oe}, 8'h01);
		@(posedge rf_clk);
		#1;
		rf_write_busy = 1'b0;
		cy(30);
		chk({7'h00, standby}, 8'h01);
		setad(1'b0, 9'h010);
		i_mst.start;
		w(sel(1'b0, 1'b1), 1'b1);
		for (int k = 0; k < 8; k++) r(k == 7, k[7:0]);
		i_mst.stop;
	endtask : t_full
	initial
	begin
		repeat (3) @(posedge clk);
		#1;
		rst_b = 1'b1;
		cy(3);
		t_rf;
		t_bad;
		t_wr;
		t_full;
		complete_run;
	end
endmodule : test_dti_i2c_slave
